// >>> hdl/pcs_pkg.sv
// Package for the per-channel substitution block.
// Assumes a 32-bit Avalon-MM host and sampled backplane/line clocks.
package pcs_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CODE_W = 8;
    localparam int CH_N   = 32;
    localparam int CH_W   = 5;
    localparam int BIT_W  = 3;
    localparam int POS_W  = 9;
    localparam int ARR_N  = 64;
    localparam int ARR_AW = 6;

    localparam logic [CH_W-1:0]   CH_T1_LIM   = 5'h18;
    localparam logic [POS_W-1:0]  POS_LAST_E1 = 9'h0ff;
    localparam logic [POS_W-1:0]  POS_LAST_T1 = 9'h0c0;
    localparam logic [POS_W-1:0]  POS_ONE     = 9'h001;
    localparam logic [BIT_W-1:0]  BIT_ROBBED  = 3'h7;
    localparam logic [ARR_AW-1:0] ARR_STEP    = 6'h01;

    localparam logic [ADDR_W-1:0] OFF_IAAR  = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_PCICR = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_CTRL  = 8'h58;
    localparam logic [ADDR_W-1:0] OFF_STAT  = 8'h5c;
    localparam logic [ADDR_W-1:0] GRP_SPAN  = 8'h10;

    // Groups of four byte registers covering 32 channels each
    localparam int GRP_TX_IE  = 0;
    localparam int GRP_RX_IE  = 1;
    localparam int GRP_TX_BLK = 2;
    localparam int GRP_RX_BLK = 3;
    localparam int GRP_TX_SEL = 4;
    localparam int GRP_N      = 5;
    localparam logic [ADDR_W-1:0] GRP_BASE [GRP_N] =
        '{8'h08, 8'h18, 8'h28, 8'h38, 8'h48};

    localparam int CTRL_T1     = 0;
    localparam int CTRL_HWSIG  = 1;
    localparam int CTRL_TX_ES  = 2;
    localparam int CTRL_SIG_CB = 3;
    localparam int CTRL_W      = 4;
    localparam int IAAR_TX_ALL = 6;
    localparam int IAAR_RX_ALL = 7;
    localparam int STAT_RX_LSB = 16;

    localparam logic [CODE_W-1:0] CODE_RST = 8'h00;
    localparam logic [CH_N-1:0]   VEC_RST  = 32'h0000_0000;
    localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
    localparam logic [POS_W-1:0]  POS_RST  = 9'h000;
endpackage

// >>> hdl/pcs_subst.sv
// Per-channel idle substitution, hardware signaling insert, blocking.
// Assumes clk_i well above the link clocks; link pins are asynchronous.
`timescale 1ns/1ps
module pcs_subst
    import pcs_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              ce_i,
    input  wire logic [ADDR_W-1:0] avs_address_i,
    input  wire logic              avs_read_i,
    input  wire logic              avs_write_i,
    input  wire logic [DATA_W-1:0] avs_writedata_i,
    input  wire logic [3:0]        avs_byteenable_i,
    output logic      [DATA_W-1:0] avs_readdata_o,
    output logic                   avs_waitrequest_o,
    input  wire logic              tx_backplane_clock_i,
    input  wire logic              tx_frame_sync_i,
    input  wire logic              tx_serial_data_in_i,
    input  wire logic              tx_signaling_in_i,
    output logic                   tx_serial_data_out_o,
    output logic                   tx_channel_block_out_o,
    input  wire logic              rx_line_clock_i,
    input  wire logic              rx_frame_sync_i,
    input  wire logic              rx_serial_data_in_i,
    output logic                   rx_serial_data_out_o,
    output logic                   rx_channel_block_out_o,
    output logic                   signaling_control_bit_o
);
    logic [CODE_W-1:0] iaar_reg;
    logic [CODE_W-1:0] iaar_next;
    logic [CODE_W-1:0] arr_reg  [ARR_N];
    logic [CODE_W-1:0] arr_next [ARR_N];
    logic [CH_N-1:0]   grp_reg  [GRP_N];
    logic [CH_N-1:0]   grp_next [GRP_N];
    logic [CTRL_W-1:0] ctrl_reg;
    logic [CTRL_W-1:0] ctrl_next;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;
    logic              ack_reg;
    logic              ack_next;
    logic              req;
    logic              acc;
    logic              wr_ok;
    logic              t1;
    logic [POS_W-1:0]  lane_pos [2];
    logic [1:0]        lane_out;
    logic [1:0]        lane_blk;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Which byte of a channel group an address hits
    function automatic logic [2:0] grp_hit(input logic [ADDR_W-1:0] a,
                                           input int g);
        logic [ADDR_W-1:0] diff;
        diff = a - GRP_BASE[g];
        return {diff < GRP_SPAN, diff[3:2]};
    endfunction

    // Frame position to {F-bit, channel, bit in channel}
    function automatic logic [8:0] dec_pos(input logic [POS_W-1:0] p,
                                           input logic tm);
        logic [POS_W-1:0] off;
        off = tm ? p - POS_ONE : p;
        return {tm && p == POS_RST, off[BIT_W+CH_W-1:BIT_W],
                off[BIT_W-1:0]};
    endfunction

    assign req   = avs_read_i | avs_write_i;
    assign acc   = req & ack_reg & ce_i;
    assign wr_ok = avs_write_i & avs_byteenable_i[0];
    assign t1    = ctrl_reg[CTRL_T1];
    // Answer one cycle after the request, never while frozen
    assign avs_waitrequest_o      = req & ~(ack_reg & ce_i);
    assign avs_readdata_o         = rdata_reg;
    assign signaling_control_bit_o = ctrl_reg[CTRL_SIG_CB];
    assign tx_serial_data_out_o   = lane_out[0];
    assign rx_serial_data_out_o   = lane_out[1];
    assign tx_channel_block_out_o = lane_blk[0];
    assign rx_channel_block_out_o = lane_blk[1];

    always_comb begin
        logic [2:0] hit;
        hit        = 3'h0;
        iaar_next  = iaar_reg;
        arr_next   = arr_reg;
        grp_next   = grp_reg;
        ctrl_next  = ctrl_reg;
        rdata_next = rdata_reg;
        // Ack drops after each answer, so back-to-back requests wait again
        ack_next   = req & ~ack_reg;
        // Read data latched on the first cycle, stands until next read
        if (avs_read_i && !ack_reg) begin
            rdata_next = '0;
            if (avs_address_i == OFF_IAAR) begin
                rdata_next[CODE_W-1:0] = iaar_reg;
            end
            if (avs_address_i == OFF_PCICR) begin
                rdata_next[CODE_W-1:0] = arr_reg[iaar_reg[ARR_AW-1:0]];
            end
            if (avs_address_i == OFF_CTRL) begin
                rdata_next[CTRL_W-1:0] = ctrl_reg;
            end
            if (avs_address_i == OFF_STAT) begin
                rdata_next[POS_W-1:0] = lane_pos[0];
                rdata_next[STAT_RX_LSB+:POS_W] = lane_pos[1];
            end
            for (int g = 0; g < GRP_N; g++) begin
                hit = grp_hit(avs_address_i, g);
                if (hit[2]) begin
                    rdata_next[CODE_W-1:0] = grp_reg[g][hit[1:0]*CODE_W
                                                         +: CODE_W];
                end
            end
        end
        if (acc && wr_ok) begin
            if (avs_address_i == OFF_IAAR) begin
                iaar_next = avs_writedata_i[CODE_W-1:0];
            end
            if (avs_address_i == OFF_CTRL) begin
                ctrl_next = avs_writedata_i[CTRL_W-1:0];
            end
            if (avs_address_i == OFF_PCICR) begin
                if (iaar_reg[IAAR_TX_ALL+:2] == 2'h0) begin
                    arr_next[iaar_reg[ARR_AW-1:0]] =
                        avs_writedata_i[CODE_W-1:0];
                end
                for (int i = 0; i < ARR_N; i++) begin
                    if (i < CH_N ? iaar_reg[IAAR_TX_ALL]
                                 : iaar_reg[IAAR_RX_ALL]) begin
                        arr_next[i] = avs_writedata_i[CODE_W-1:0];
                    end
                end
                iaar_next[ARR_AW-1:0] = iaar_reg[ARR_AW-1:0] + ARR_STEP;
            end
            for (int g = 0; g < GRP_N; g++) begin
                hit = grp_hit(avs_address_i, g);
                if (hit[2]) begin
                    grp_next[g][hit[1:0]*CODE_W +: CODE_W] =
                        avs_writedata_i[CODE_W-1:0];
                end
            end
        end
        if (acc && avs_read_i && avs_address_i == OFF_PCICR) begin
            iaar_next[ARR_AW-1:0] = iaar_reg[ARR_AW-1:0] + ARR_STEP;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            iaar_reg  <= CODE_RST;
            arr_reg   <= '{default: CODE_RST};
            grp_reg   <= '{default: VEC_RST};
            ctrl_reg  <= CTRL_RST;
            rdata_reg <= '0;
            ack_reg   <= 1'b0;
        end else if (ce_i) begin
            iaar_reg  <= iaar_next;
            arr_reg   <= arr_next;
            grp_reg   <= grp_next;
            ctrl_reg  <= ctrl_next;
            rdata_reg <= rdata_next;
            ack_reg   <= ack_next;
        end
    end

    // Lane 0 transmit (backplane to line), lane 1 receive
    for (genvar d = 0; d < 2; d++) begin : g_lane
        localparam int GI = (d == 0) ? GRP_TX_IE  : GRP_RX_IE;
        localparam int GB = (d == 0) ? GRP_TX_BLK : GRP_RX_BLK;
        logic [3:0]       raw;
        logic [3:0]       s1_reg;
        logic [3:0]       s2_reg;
        logic             clk_q_reg;
        logic [POS_W-1:0] pos_reg;
        logic [POS_W-1:0] pos_next;
        logic             out_reg;
        logic             out_next;
        logic             blk_reg;
        logic             blk_next;
        logic             in_reg;
        logic             in_next;
        logic             sig_reg;
        logic             sig_next;
        logic             rise;
        logic [8:0]       cd;
        logic [8:0]       pd;
        logic [CH_W-1:0]  pch;
        logic [BIT_W-1:0] pbi;
        logic             pok;
        logic             psub;
        logic             psig;

        if (d == 0) begin : g_raw_tx
            assign raw = {tx_signaling_in_i, tx_serial_data_in_i,
                          tx_frame_sync_i, tx_backplane_clock_i};
        end else begin : g_raw_rx
            assign raw = {1'b0, rx_serial_data_in_i,
                          rx_frame_sync_i, rx_line_clock_i};
        end

        assign rise        = s2_reg[0] & ~clk_q_reg;
        assign lane_pos[d] = pos_reg;
        assign lane_out[d] = out_reg;
        assign lane_blk[d] = blk_reg;
        assign pd   = dec_pos(pos_reg, t1);
        assign pch  = pd[BIT_W+CH_W-1:BIT_W];
        assign pbi  = pd[BIT_W-1:0];
        assign pok  = !pd[8] && (!t1 || pch < CH_T1_LIM);
        assign psub = pok && grp_reg[GI][pch];
        assign psig = (d == 0) && ctrl_reg[CTRL_HWSIG] && !pd[8]
                      && grp_reg[GRP_TX_SEL][pch]
                      && (!t1 || pbi == BIT_ROBBED);

        always_comb begin
            logic [POS_W-1:0] cur;
            logic [CH_W-1:0]  ch;
            logic [BIT_W-1:0] bi;
            logic             ok;
            cur      = POS_RST;
            ch       = '0;
            bi       = '0;
            ok       = 1'b0;
            cd       = '0;
            pos_next = pos_reg;
            out_next = out_reg;
            blk_next = blk_reg;
            in_next  = in_reg;
            sig_next = sig_reg;
            if (rise) begin
                if (!s2_reg[1] &&
                    pos_reg < (t1 ? POS_LAST_T1 : POS_LAST_E1)) begin
                    cur = pos_reg + POS_ONE;
                end
                cd = dec_pos(cur, t1);
                ch = cd[BIT_W+CH_W-1:BIT_W];
                bi = cd[BIT_W-1:0];
                ok = !cd[8] && (!t1 || ch < CH_T1_LIM);
                pos_next = cur;
                in_next  = s2_reg[2];
                sig_next = s2_reg[3];
                out_next = s2_reg[2];
                if (d == 0 && ctrl_reg[CTRL_HWSIG] && !cd[8]
                    && grp_reg[GRP_TX_SEL][ch]
                    && (!t1 || bi == BIT_ROBBED)) begin
                    out_next = s2_reg[3];
                end
                // Later assignment: idle code wins over signaling
                // idle code MSB first
                if (ok && grp_reg[GI][ch]) begin
                    out_next = arr_reg[d*CH_N+ch][CODE_W-1-bi];
                end
                blk_next = ok && grp_reg[GB][ch];
            end
        end

        // Two-stage synchroniser; only stage two feeds logic
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                s1_reg    <= 4'h0;
                s2_reg    <= 4'h0;
                clk_q_reg <= 1'b0;
                pos_reg   <= POS_RST;
                out_reg   <= 1'b0;
                blk_reg   <= 1'b0;
                in_reg    <= 1'b0;
                sig_reg   <= 1'b0;
            end else if (ce_i) begin
                s1_reg    <= raw;
                s2_reg    <= s1_reg;
                clk_q_reg <= s2_reg[0];
                pos_reg   <= pos_next;
                out_reg   <= out_next;
                blk_reg   <= blk_next;
                in_reg    <= in_next;
                sig_reg   <= sig_next;
            end
        end

        sub_out_a: assert property (
            $past(rise & ce_i) && !$past(acc) && psub
            |-> out_reg == arr_reg[d*CH_N+pch][CODE_W-1-pbi])
            else $error("idle code bit not on output");
        pass_thru_a: assert property (
            $past(rise & ce_i) && !$past(acc) && !psub && !psig
            |-> out_reg == in_reg)
            else $error("unselected channel data altered");
        blk_out_a: assert property (
            $past(rise & ce_i) && !$past(acc)
            |-> blk_reg == (pok && grp_reg[GB][pch]))
            else $error("blocking output wrong for channel");
        t1_block_a: assert property (
            $past(rise & ce_i) && t1 && $past(t1) && blk_reg
            |-> pch < CH_T1_LIM)
            else $error("blocking active beyond channel 24");
        pos_range_a: assert property (
            $past(rise & ce_i) && !$past(acc) && !t1
            |-> pos_reg <= POS_LAST_E1 && pd[8] == 1'b0)
            else $error("frame position out of range");
        // T1 framing bit is never substituted, signaled or blocked
        f_bit_a: assert property (
            $past(rise & ce_i) && !$past(acc) && t1 && pd[8]
            |-> out_reg == in_reg && !blk_reg)
            else $error("framing bit altered");
        blk_seen_c: cover property (blk_reg ##1 !blk_reg);
        if (d == 0) begin : g_sig_chk
            sig_ins_a: assert property (
                $past(rise & ce_i) && !$past(acc) && psig && !psub
                |-> out_reg == sig_reg)
                else $error("signaling bit not inserted");
            sub_seen_c: cover property ($past(rise) && psub);
        end
    end

    // One wait cycle, then the answer while clock enable stays high
    wait_one_a: assert property (
        req && !ack_reg && ce_i ##1 req && ce_i |-> !avs_waitrequest_o)
        else $error("waitrequest not released after one cycle");

    // Frozen clock enable keeps IAAR, control, ack and array entry 0 as they were
    hold_state_a: assert property (
        !ce_i |=> iaar_reg == $past(iaar_reg) && ctrl_reg == $past(ctrl_reg)
            && ack_reg == $past(ack_reg) && arr_reg[0] == $past(arr_reg[0]))
        else $error("state changed while clock enable low");

    // Read data stands until the next read is taken
    rd_hold_a: assert property (
        !avs_read_i |=> avs_readdata_o == $past(avs_readdata_o))
        else $error("read data changed without a read");

    inc_wr_a: assert property (
        acc && wr_ok && avs_address_i == OFF_PCICR
        |=> iaar_reg[ARR_AW-1:0] == $past(iaar_reg[ARR_AW-1:0]) + ARR_STEP)
        else $error("address did not step after write");
    inc_rd_a: assert property (
        acc && avs_read_i && avs_address_i == OFF_PCICR
        |=> iaar_reg[ARR_AW-1:0] == $past(iaar_reg[ARR_AW-1:0]) + ARR_STEP)
        else $error("address did not step after read");
    one_wr_a: assert property (
        acc && wr_ok && avs_address_i == OFF_PCICR
        && iaar_reg[IAAR_TX_ALL+:2] == 2'h0
        |=> arr_reg[$past(iaar_reg[ARR_AW-1:0])]
            == $past(avs_writedata_i[CODE_W-1:0]))
        else $error("single idle code not stored");
    blk_fill_a: assert property (
        acc && wr_ok && avs_address_i == OFF_PCICR
        && iaar_reg[IAAR_TX_ALL] && iaar_reg[IAAR_RX_ALL]
        |=> arr_reg[0] == $past(avs_writedata_i[CODE_W-1:0])
            && arr_reg[ARR_N-1] == $past(avs_writedata_i[CODE_W-1:0]))
        else $error("block write missed a position");
    rd_word_a: assert property (
        avs_read_i && !ack_reg && ce_i && avs_address_i == OFF_PCICR
        ##1 acc
        |-> rdata_reg[CODE_W-1:0] == $past(arr_reg[iaar_reg[ARR_AW-1:0]]))
        else $error("array read data wrong");
    blk_wr_c: cover property (acc && wr_ok
        && avs_address_i == OFF_PCICR && iaar_reg[IAAR_TX_ALL]);
    rd_inc_c: cover property (acc && avs_read_i
        && avs_address_i == OFF_PCICR);
    t1_wrap_c: cover property (t1 && lane_pos[0] == POS_LAST_T1);
endmodule

// >>> testbench/pcs_link_model.sv
// Far-side link model: free bit clock, frame sync, data, signaling.
// Assumes the bench reads pos_o at every link clock rise.
`timescale 1ns/1ps
module pcs_link_model
    import pcs_pkg::*;
(
    input  wire logic             t1_i,
    output logic                  link_clk_o,
    output logic                  sync_o,
    output logic                  data_o,
    output logic                  sig_o,
    output logic      [POS_W-1:0] pos_o
);
    // Channel c carries 5Ah ^ c, MSB first; T1 F bit is 1
    function automatic logic in_bit(input int p, input logic t1);
        int         q;
        logic [7:0] b;
        q = t1 ? p - 1 : p;
        b = 8'h5a ^ 8'(q / 8);
        if (t1 && p == 0) begin
            return 1'b1;
        end
        return b[7 - q % 8];
    endfunction

    initial begin
        link_clk_o = 1'b0;
        pos_o      = POS_RST;
        sync_o     = 1'b1;
        data_o     = in_bit(0, t1_i);
        sig_o      = ~data_o;
        // Odd offset keeps link edges off the system clock edges
        #13;
        forever begin
            #200 link_clk_o = 1'b1;
            #200 link_clk_o = 1'b0;
            if (pos_o >= (t1_i ? POS_LAST_T1 : POS_LAST_E1)) begin
                pos_o = POS_RST;
            end else begin
                pos_o = pos_o + POS_ONE;
            end
            sync_o = (pos_o == POS_RST);
            data_o = in_bit(int'(pos_o), t1_i);
            // signaling bit beside each data bit
            sig_o  = ~data_o;
        end
    end
endmodule

// >>> testbench/testbench.sv
// Self-checking bench: Avalon register tasks and link stream compares.
// Assumes one link model per direction on the far side.
`timescale 1ns/1ps
module testbench
    import pcs_pkg::*;
;
    // tx channels 0 and 16 left off
    localparam logic [DATA_W-1:0] VALS [GRP_N] = '{32'hf0fe_0f3c,
        32'h0f01_a55a, 32'hff00_8181, 32'h8000_0ff0, 32'h0000_c3c3};
    logic              clk_i, rst_i, ce_i, avs_read_i, avs_write_i;
    logic [ADDR_W-1:0] avs_address_i;
    logic [DATA_W-1:0] avs_writedata_i, avs_readdata_o;
    logic [3:0]        avs_byteenable_i;
    logic              avs_waitrequest_o, t1_mode, signaling_control_bit_o;
    logic              tx_backplane_clock_i, tx_frame_sync_i;
    logic              tx_serial_data_in_i, tx_signaling_in_i;
    logic              tx_serial_data_out_o, tx_channel_block_out_o;
    logic              rx_line_clock_i, rx_frame_sync_i, rx_serial_data_in_i;
    logic              rx_serial_data_out_o, rx_channel_block_out_o;
    logic [POS_W-1:0]  tx_pos, rx_pos;
    int                checks, mismatches, k;

    pcs_subst i_pcs_subst (
        .clk_i, .rst_i, .ce_i, .avs_address_i, .avs_read_i, .avs_write_i,
        .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
        .avs_waitrequest_o, .tx_backplane_clock_i, .tx_frame_sync_i,
        .tx_serial_data_in_i, .tx_signaling_in_i, .tx_serial_data_out_o,
        .tx_channel_block_out_o, .rx_line_clock_i, .rx_frame_sync_i,
        .rx_serial_data_in_i, .rx_serial_data_out_o,
        .rx_channel_block_out_o, .signaling_control_bit_o
    );
    pcs_link_model i_tx_model (.t1_i(t1_mode),
        .link_clk_o(tx_backplane_clock_i), .sync_o(tx_frame_sync_i),
        .data_o(tx_serial_data_in_i), .sig_o(tx_signaling_in_i),
        .pos_o(tx_pos));
    pcs_link_model i_rx_model (.t1_i(t1_mode),
        .link_clk_o(rx_line_clock_i), .sync_o(rx_frame_sync_i),
        .data_o(rx_serial_data_in_i), .sig_o(), .pos_o(rx_pos));

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        close_out();
    end

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [7:0] d, input logic [3:0] b,
                       output logic [31:0] q);
        @(posedge clk_i);
        avs_address_i    <= a;
        avs_writedata_i  <= {24'h00_0000, d};
        avs_byteenable_i <= b;
        avs_write_i      <= w;
        avs_read_i       <= ~w;
        do begin
            @(posedge clk_i);
        end while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i  <= 1'b0;
    endtask

    task automatic wr8(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, 4'h1, q);
    endtask

    task automatic rd_chk(input string name, input logic [7:0] a,
                          input logic [7:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, 4'h1, q);
        check(name, q, {24'h00_0000, exp});
    endtask

    function automatic logic [7:0] code_of(input int k);
        return 8'(k) * 8'h25 ^ 8'h81;
    endfunction

    // Outputs at a link rise belong to the bit one rise earlier
    task automatic check_dir(input int dir, input int n);
        int         p, q, len;
        logic       e_d, e_b, din, s_d, s_b;
        logic [7:0] c;
        len = t1_mode ? 193 : 256;
        repeat (n) begin
            if (dir == 0) begin
                @(posedge tx_backplane_clock_i);
                p = int'(tx_pos);
                s_d = tx_serial_data_out_o;
                s_b = tx_channel_block_out_o;
            end else begin
                @(posedge rx_line_clock_i);
                p = int'(rx_pos);
                s_d = rx_serial_data_out_o;
                s_b = rx_channel_block_out_o;
            end
            p = (p + len - 1) % len;
            q = t1_mode ? p - 1 : p;
            c = code_of(32 * dir + q / 8);
            din = i_tx_model.in_bit(p, t1_mode);
            e_d = din;
            e_b = 1'b0;
            if (!t1_mode || p != 0) begin
                e_b = VALS[GRP_TX_BLK + dir][q / 8];
                if (VALS[GRP_TX_IE + dir][q / 8]) begin
                    e_d = c[7 - q % 8];
                end else if (dir == 0 && VALS[GRP_TX_SEL][q / 8] &&
                             (!t1_mode || q % 8 == 7)) begin
                    e_d = ~din;
                end
            end
            check("link data", 32'(s_d), 32'(e_d)); // data
            check("block out", 32'(s_b), 32'(e_b)); // block
        end
    endtask

    initial begin
        logic [31:0] q;
        rst_i            = 1'b1;
        ce_i             = 1'b1;
        avs_read_i       = 1'b0;
        avs_write_i      = 1'b0;
        avs_address_i    = 8'h00;
        avs_writedata_i  = 32'h0000_0000;
        avs_byteenable_i = 4'h0;
        t1_mode          = 1'b0;
        checks           = 0;
        mismatches       = 0;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        for (k = 0; k <= int'(OFF_CTRL); k += 4) begin
            rd_chk("reset value", 8'(k), 8'h00); // cleared
        end
        wr8(8'h60, 8'hff);
        rd_chk("unmapped", 8'h60, 8'h00); // outside map
        for (int g = 0; g < GRP_N; g++) begin
            for (k = 0; k < 4; k++) begin
                wr8(GRP_BASE[g] + 8'(4 * k), VALS[g][8 * k +: 8]);
                rd_chk("enable reg", GRP_BASE[g] + 8'(4 * k),
                       VALS[g][8 * k +: 8]); // bit order
            end
        end
        bus(1'b1, GRP_BASE[0], 8'h00, 4'h0, q);
        rd_chk("no lane", GRP_BASE[0], VALS[0][7:0]); // kept
        wr8(OFF_IAAR, 8'h02);
        for (k = 0; k < 4; k++) begin
            wr8(OFF_PCICR, code_of(k));
        end
        rd_chk("addr after writes", OFF_IAAR, 8'h06); // step
        wr8(OFF_IAAR, 8'h02);
        for (k = 0; k < 4; k++) begin
            rd_chk("code read", OFF_PCICR, code_of(k)); // read
        end
        rd_chk("addr after reads", OFF_IAAR, 8'h06); // step
        wr8(OFF_IAAR, 8'h40);
        wr8(OFF_PCICR, 8'h55);
        rd_chk("block addr", OFF_IAAR, 8'h41); // bits kept
        wr8(OFF_IAAR, 8'h80);
        wr8(OFF_PCICR, 8'h66);
        wr8(OFF_IAAR, 8'h1f);
        rd_chk("tx block", OFF_PCICR, 8'h55); // tx half
        rd_chk("rx block", OFF_PCICR, 8'h66); // rx half
        wr8(OFF_IAAR, 8'hc0);
        wr8(OFF_PCICR, 8'h7e);
        wr8(OFF_IAAR, 8'h3f);
        rd_chk("both block", OFF_PCICR, 8'h7e); // entry 63 only
        rd_chk("wrap", OFF_IAAR, 8'h00); // wraps to zero
        wr8(OFF_IAAR, 8'h00);
        for (k = 0; k < ARR_N; k++) begin
            wr8(OFF_PCICR, code_of(k));
        end
        for (k = 0; k < ARR_N; k++) begin
            rd_chk("array", OFF_PCICR, code_of(k)); // map
        end
        // Clock enable low mid-request: answer waits, one step only
        fork
            rd_chk("frozen read", OFF_PCICR, code_of(0)); // read
            begin
                @(posedge clk_i);
                ce_i <= 1'b0;
                repeat (3) @(posedge clk_i);
                ce_i <= 1'b1;
            end
        join
        rd_chk("frozen step", OFF_IAAR, 8'h01); // one step
        wr8(OFF_CTRL, 8'h0a);
        rd_chk("control", OFF_CTRL, 8'h0a); // enable stored
        check("ctl bit", 32'(signaling_control_bit_o), 32'h0000_0001);
        repeat (4) @(posedge tx_backplane_clock_i);
        fork
            check_dir(0, 256); // E1 frame
            check_dir(1, 256); // E1 receive
        join
        // elastic store on, control bit cleared
        wr8(OFF_CTRL, 8'h07);
        rd_chk("control t1", OFF_CTRL, 8'h07); // stored
        check("ctl clear", 32'(signaling_control_bit_o), 32'h0000_0000);
        t1_mode <= 1'b1;
        repeat (400) @(posedge tx_backplane_clock_i);
        fork
            check_dir(0, 193); // T1 frame
            check_dir(1, 193); // T1 receive
        join
        close_out();
    end
endmodule
